//--- src/lsc_pkg.sv
// Constants, register map and state type of the laser shutdown controller.
package lsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 5;
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_DELAY     = 5'h04;
  localparam logic [4:0]  OFS_CMD       = 5'h08;
  localparam logic [4:0]  OFS_STATUS    = 5'h0C;
  localparam logic [4:0]  OFS_INT_STAT  = 5'h10;
  localparam logic [4:0]  OFS_INT_CLR   = 5'h14;
  localparam logic [4:0]  OFS_INT_EN    = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_AUTO_BIT = 1;
  localparam int          CMD_RESTART   = 0;
  localparam int          CMD_OVERRIDE  = 1;
  localparam int          CMD_CANCEL    = 2;
  localparam int          EV_SHUTDOWN   = 0;
  localparam int          EV_RESTART    = 1;
  localparam int          EV_CLEARED    = 2;
  localparam int          EV_W          = 3;

  // ----------------------------------------------------------------
  // Reset values and delay limits
  // ----------------------------------------------------------------
  localparam logic        RST_CTRL_EN   = 1'b0;
  localparam logic        RST_CTRL_AUTO = 1'b1;
  localparam logic [8:0]  DELAY_MIN_S   = 9'h03C;
  localparam logic [8:0]  DELAY_MAX_S   = 9'h12C;
  localparam logic [8:0]  RST_DELAY_S   = 9'h03C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          MS_NS         = 1000000;
  localparam int          CYC_PER_MS_D  = MS_NS / CLK_PERIOD_NS;
  localparam logic [18:0] MS_PER_S      = 19'h003E8;
  localparam int          PROBE_MIN_MS  = 1750;
  localparam int          PROBE_MAX_MS  = 2250;
  localparam logic [18:0] PROBE_MS      = 19'((PROBE_MIN_MS + PROBE_MAX_MS) / 2);

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {ST_ON, ST_OFF, ST_PROBE, ST_OVR} lsc_state_t;

endpackage

//--- src/lsc_laser_shutdown.sv
// Automatic laser shutdown controller with an AXI4-Lite register slave.
`timescale 1ns/10ps
module lsc_laser_shutdown import lsc_pkg::*; #(
  parameter int CYC_PER_MS = CYC_PER_MS_D
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              signal_lost,
  output logic                   laser_en_r,
  output logic                   shutdown_alarm_r,
  output logic                   irq_r,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic              aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0]       w_data_r, w_data_nxt;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]        bresp_nxt, rresp_nxt;
  logic [31:0]       rdata_nxt;
  logic              wr_fire, wr_ok, rd_ok;
  logic [31:0]       rd_val;

  // Core state, declared here because the read mux needs it.
  lsc_state_t        st_r, st_nxt;
  logic              ctrl_en_r, ctrl_en_nxt, ctrl_auto_r, ctrl_auto_nxt;
  logic [8:0]        delay_s_r, delay_s_nxt;
  logic              restart_p_r, restart_p_nxt, override_p_r, override_p_nxt;
  logic              cancel_p_r, cancel_p_nxt;
  logic [EV_W-1:0]   int_stat_r, int_stat_nxt, int_en_r, int_en_nxt, ev;
  logic [31:0]       ms_cnt_r, ms_cnt_nxt;
  logic [18:0]       el_ms_r, el_ms_nxt, delay_ms;
  logic              ms_tick, laser_nxt, alarm_nxt, irq_nxt;

  // A write commits only once both address and data are held, so the two
  // channels may arrive in either order.
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ok   = (aw_addr_r == OFS_CTRL) || (aw_addr_r == OFS_DELAY) ||
                   (aw_addr_r == OFS_CMD) || (aw_addr_r == OFS_INT_CLR) ||
                   (aw_addr_r == OFS_INT_EN);

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      OFS_CTRL:     rd_val = {30'h00000000, ctrl_auto_r, ctrl_en_r};
      OFS_DELAY:    rd_val = {23'h000000, delay_s_r};
      OFS_CMD:      rd_val = 32'h00000000;
      OFS_STATUS:   rd_val = {26'h0000000, st_r, 1'b0, signal_lost, shutdown_alarm_r,
                              laser_en_r};
      OFS_INT_STAT: rd_val = {29'h00000000, int_stat_r};
      OFS_INT_CLR:  rd_val = 32'h00000000;
      OFS_INT_EN:   rd_val = {29'h00000000, int_en_r};
      default:      rd_ok  = 1'b0;
    endcase
  end

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt  = w_hold_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = s_axi_bvalid;
    bresp_nxt   = s_axi_bresp;
    rvalid_nxt  = s_axi_rvalid;
    rresp_nxt   = s_axi_rresp;
    rdata_nxt   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = rd_val;
      rresp_nxt  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_hold_nxt;
    wready_nxt  = !w_hold_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      aw_addr_r     <= '0;
      w_hold_r      <= 1'b0;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      aw_hold_r     <= aw_hold_nxt;
      aw_addr_r     <= aw_addr_nxt;
      w_hold_r      <= w_hold_nxt;
      w_data_r      <= w_data_nxt;
      w_strb_r      <= w_strb_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rresp   <= rresp_nxt;
      s_axi_rdata   <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown core
  // ----------------------------------------------------------------
  assign ms_tick  = (ms_cnt_r == 32'(CYC_PER_MS - 1));
  assign delay_ms = 19'(delay_s_r) * MS_PER_S;

  always_comb begin
    logic [15:0] dmerge;
    dmerge         = {w_strb_r[1] ? w_data_r[15:8] : {7'h00, delay_s_r[8]},
                      w_strb_r[0] ? w_data_r[7:0] : delay_s_r[7:0]};
    ctrl_en_nxt    = ctrl_en_r;
    ctrl_auto_nxt  = ctrl_auto_r;
    delay_s_nxt    = delay_s_r;
    int_en_nxt     = int_en_r;
    restart_p_nxt  = 1'b0;
    override_p_nxt = 1'b0;
    cancel_p_nxt   = 1'b0;
    ev             = '0;
    st_nxt         = st_r;
    ms_cnt_nxt     = ms_tick ? 32'h00000000 : ms_cnt_r + 32'h00000001;
    el_ms_nxt      = ms_tick ? el_ms_r + 19'h00001 : el_ms_r;
    if (wr_fire && w_strb_r[0]) begin
      case (aw_addr_r)
        OFS_CTRL: begin
          ctrl_en_nxt   = w_data_r[CTRL_EN_BIT];
          ctrl_auto_nxt = w_data_r[CTRL_AUTO_BIT];
        end
        OFS_CMD: begin
          restart_p_nxt  = w_data_r[CMD_RESTART];
          override_p_nxt = w_data_r[CMD_OVERRIDE];
          cancel_p_nxt   = w_data_r[CMD_CANCEL];
        end
        OFS_INT_EN: int_en_nxt = w_data_r[EV_W-1:0];
        default: ;
      endcase
    end
    // The delay is clamped so that software cannot program a restart
    // sooner than the laser-safety minimum.
    if (wr_fire && aw_addr_r == OFS_DELAY && (w_strb_r[0] || w_strb_r[1])) begin
      if (dmerge < 16'(DELAY_MIN_S))
        delay_s_nxt = DELAY_MIN_S;
      else if (dmerge > 16'(DELAY_MAX_S))
        delay_s_nxt = DELAY_MAX_S;
      else
        delay_s_nxt = dmerge[8:0];
    end
    case (st_r)
      ST_ON: begin
        if (ctrl_en_r && signal_lost) begin
          st_nxt = ST_OFF;
          ev[EV_SHUTDOWN] = 1'b1;
        end
      end
      ST_OFF: begin
        if (!signal_lost) begin
          st_nxt = ST_ON;
          ev[EV_CLEARED] = 1'b1;
        end else if (override_p_r) begin
          st_nxt = ST_OVR;
        end else if (ctrl_auto_r ? (el_ms_r >= delay_ms) : restart_p_r) begin
          st_nxt = ST_PROBE;
          ev[EV_RESTART] = 1'b1;
        end
      end
      ST_PROBE: begin
        if (!signal_lost) begin
          st_nxt = ST_ON;
          ev[EV_CLEARED] = 1'b1;
        end else if (override_p_r) begin
          st_nxt = ST_OVR;
        end else if (el_ms_r >= PROBE_MS) begin
          st_nxt = ST_OFF;
          ev[EV_SHUTDOWN] = 1'b1;
        end
      end
      ST_OVR: begin
        if (!signal_lost || cancel_p_r) begin
          st_nxt = ST_ON;
          ev[EV_CLEARED] = !signal_lost;
        end
      end
      default: st_nxt = ST_ON;
    endcase
    if (!ctrl_en_r)
      st_nxt = ST_ON;
    // Each phase measures its time from its own start.
    if (st_nxt != st_r) begin
      ms_cnt_nxt = 32'h00000000;
      el_ms_nxt  = 19'h00000;
    end
    laser_nxt = (st_nxt != ST_OFF);
    alarm_nxt = ctrl_en_nxt && signal_lost;
    // A new event wins over a clear written in the same cycle.
    int_stat_nxt = int_stat_r;
    if (wr_fire && aw_addr_r == OFS_INT_CLR && w_strb_r[0])
      int_stat_nxt = int_stat_r & ~w_data_r[EV_W-1:0];
    int_stat_nxt = int_stat_nxt | ev;
    irq_nxt      = |(int_stat_nxt & int_en_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r             <= ST_ON;
      ctrl_en_r        <= RST_CTRL_EN;
      ctrl_auto_r      <= RST_CTRL_AUTO;
      delay_s_r        <= RST_DELAY_S;
      restart_p_r      <= 1'b0;
      override_p_r     <= 1'b0;
      cancel_p_r       <= 1'b0;
      int_stat_r       <= '0;
      int_en_r         <= '0;
      ms_cnt_r         <= 32'h00000000;
      el_ms_r          <= 19'h00000;
      laser_en_r       <= 1'b1;
      shutdown_alarm_r <= 1'b0;
      irq_r            <= 1'b0;
    end else begin
      st_r             <= st_nxt;
      ctrl_en_r        <= ctrl_en_nxt;
      ctrl_auto_r      <= ctrl_auto_nxt;
      delay_s_r        <= delay_s_nxt;
      restart_p_r      <= restart_p_nxt;
      override_p_r     <= override_p_nxt;
      cancel_p_r       <= cancel_p_nxt;
      int_stat_r       <= int_stat_nxt;
      int_en_r         <= int_en_nxt;
      ms_cnt_r         <= ms_cnt_nxt;
      el_ms_r          <= el_ms_nxt;
      laser_en_r       <= laser_nxt;
      shutdown_alarm_r <= alarm_nxt;
      irq_r            <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_disabled_laser_on: assert property (
    @(posedge aclk) disable iff (!aresetn) !ctrl_en_r |=> laser_en_r)
    else $error("Laser off while shutdown feature disabled.");

  a_loss_shuts_laser: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r == ST_ON && ctrl_en_r && signal_lost) |=> (!laser_en_r && st_r == ST_OFF))
    else $error("Signal loss did not shut the laser down.");

  a_alarm_tracks_loss: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ##1 shutdown_alarm_r == ($past(ctrl_en_nxt) && $past(signal_lost)))
    else $error("Shutdown alarm does not follow signal loss.");

  a_auto_delay_bound: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r == ST_OFF && ctrl_auto_r && ctrl_en_r && $stable(delay_s_r) && $stable(ctrl_auto_r))
    |-> (el_ms_r <= delay_ms && !laser_en_r))
    else $error("Automatic restart delay overrun or laser on.");

  a_probe_window: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r == ST_PROBE) |-> (el_ms_r <= PROBE_MS && laser_en_r))
    else $error("Restart probe window overrun.");

  a_manual_waits: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r == ST_OFF && !ctrl_auto_r && !restart_p_r && !override_p_r &&
     signal_lost && ctrl_en_r && ctrl_en_nxt) |=> (st_r == ST_OFF && !laser_en_r))
    else $error("Manual mode restarted without command.");

  a_override_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r == ST_OVR) |-> laser_en_r)
    else $error("Laser off during override.");

  a_clear_ends_cycle: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (st_r == ST_PROBE && !signal_lost) |=> (st_r == ST_ON && laser_en_r && !shutdown_alarm_r))
    else $error("Loss clear did not end the shutdown cycle.");

endmodule

//--- tb/lsc_optics_model.sv
// Model of the optical receiver loss detector and the transmit laser driver.
`timescale 1ns/10ps
module lsc_optics_model (
  input  wire logic aclk,
  input  wire logic fiber_cut,
  input  wire logic laser_en,
  output logic      signal_lost,
  output logic      tx_light
);
  // ------------------------------------------------------------
  // Detector and driver
  // ------------------------------------------------------------
  // The detector needs one clock to declare loss, so the block never sees a same-cycle change.
  always @(posedge aclk) begin
    signal_lost <= fiber_cut;
  end
  assign tx_light = laser_en;
endmodule

//--- tb/lsc_laser_shutdown_tb_top.sv
// Self-checking testbench of the laser shutdown controller.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module lsc_laser_shutdown_tb_top;
  import lsc_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  // One cycle per millisecond keeps the 60 second delay inside the run budget.
  localparam int CPM = 1;
  logic              aclk;
  logic              aresetn;
  logic              fiber_cut;
  logic              signal_lost;
  logic              laser_en_r;
  logic              shutdown_alarm_r;
  logic              irq_r;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  logic [31:0]       d;
  logic [1:0]        rsp;
  int                n_errors;
  int                n_compared;

  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  lsc_laser_shutdown #(.CYC_PER_MS(CPM)) lsc_laser_shutdown_i (
    .aclk(aclk), .aresetn(aresetn), .signal_lost(signal_lost), .laser_en_r(laser_en_r),
    .shutdown_alarm_r(shutdown_alarm_r), .irq_r(irq_r),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  lsc_optics_model lsc_optics_model_i (
    .aclk(aclk), .fiber_cut(fiber_cut), .laser_en(laser_en_r),
    .signal_lost(signal_lost), .tx_light()
  );

  // ------------------------------------------------------------
  // Bus and timing tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Counts cycles until the laser shows v and checks the count falls in lo..hi+1.
  task automatic wait_laser(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (laser_en_r !== v && n <= hi) begin
      @(posedge aclk);
      n++;
    end
    `CHK("laser change time", 1'b1, (laser_en_r === v && n >= lo))
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    n_errors = 0;
    n_compared = 0;
    aresetn = 1'b0;
    fiber_cut = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("laser at reset", 1'b1, laser_en_r)
    rd(OFS_CTRL);
    `CHK("ctrl reset", 32'h00000002, d)
    rd(OFS_DELAY);
    `CHK("delay reset", 32'h0000003C, d)
    rd(5'h1C);
    `CHK("unmapped read resp", RESP_SLVERR, rsp)
    wr(5'h1C, 32'h00000001);
    `CHK("unmapped write resp", RESP_SLVERR, rsp)
    // Feature off: loss must leave the laser alone.
    fiber_cut <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK("laser while disabled", 1'b1, laser_en_r)
    `CHK("alarm while disabled", 1'b0, shutdown_alarm_r)
    fiber_cut <= 1'b0;
    wr(OFS_INT_EN, 32'h00000007);
    wr(OFS_CTRL, 32'h00000001);
    fiber_cut <= 1'b1;
    wait_laser(1'b0, 0, 5);
    `CHK("alarm on loss", 1'b1, shutdown_alarm_r)
    `CHK("irq on shutdown", 1'b1, irq_r)
    rd(OFS_INT_STAT);
    `CHK("shutdown event", 1'b1, d[EV_SHUTDOWN])
    wr(OFS_INT_CLR, 32'h00000007);
    `CHK("irq after clear", 1'b0, irq_r)
    repeat (2500 * CPM) @(posedge aclk);
    `CHK("manual stays off", 1'b0, laser_en_r)
    wr(OFS_CMD, 32'h00000001);
    wait_laser(1'b1, 0, 5);
    wait_laser(1'b0, 1750 * CPM, 2250 * CPM);
    wr(OFS_CMD, 32'h00000002);
    wait_laser(1'b1, 0, 5);
    repeat (3000 * CPM) @(posedge aclk);
    `CHK("override holds laser", 1'b1, laser_en_r)
    `CHK("alarm in override", 1'b1, shutdown_alarm_r)
    rd(OFS_STATUS);
    `CHK("status in override", 32'h00000037, d)
    wr(OFS_CMD, 32'h00000004);
    wait_laser(1'b0, 0, 5);
    wr(OFS_CMD, 32'h00000002);
    wait_laser(1'b1, 0, 5);
    fiber_cut <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK("alarm after clear", 1'b0, shutdown_alarm_r)
    `CHK("laser after clear", 1'b1, laser_en_r)
    rd(OFS_INT_STAT);
    `CHK("cleared event", 1'b1, d[EV_CLEARED])
    // Loss clears inside the probe window: the cycle must stop there.
    fiber_cut <= 1'b1;
    wait_laser(1'b0, 0, 5);
    wr(OFS_CMD, 32'h00000001);
    wait_laser(1'b1, 0, 5);
    fiber_cut <= 1'b0;
    repeat (2500 * CPM) @(posedge aclk);
    `CHK("probe ends on clear", 1'b1, laser_en_r)
    `CHK("alarm drops", 1'b0, shutdown_alarm_r)
    wr(OFS_DELAY, 32'h000003FF);
    rd(OFS_DELAY);
    `CHK("delay upper clamp", 32'h0000012C, d)
    wr(OFS_DELAY, 32'h00000000);
    rd(OFS_DELAY);
    `CHK("delay lower clamp", 32'h0000003C, d)
    wr(OFS_INT_CLR, 32'h00000007);
    wr(OFS_CTRL, 32'h00000003);
    fiber_cut <= 1'b1;
    wait_laser(1'b0, 0, 5);
    wait_laser(1'b1, 59900 * CPM, 60100 * CPM);
    wait_laser(1'b0, 1750 * CPM, 2250 * CPM);
    rd(OFS_INT_STAT);
    `CHK("restart event", 1'b1, d[EV_RESTART])
    fiber_cut <= 1'b0;
    wait_laser(1'b1, 0, 5);
    results;
  end

  // A full run is about 72000 cycles; the watchdog leaves some margin.
  initial begin
    repeat (90000) @(posedge aclk);
    n_errors++;
    results;
  end
endmodule
